// *** rtl/ces_exposure_sequencer.sv ***
// exposure sequencer: clean, open compensation, exposure, close compensation, readout
// assumes an APB master on ref_clk and a trigger pin from outside the clock domain
//
// Notes on behaviour
// - charge accumulates only in exposure, which the stop command or, in auto mode, the exposure timer ends
// - sensor is cleaned while idle; the start command and trigger end cleaning
// - in triggered mode cleaning runs right up to each opening compensation
// - exposure end leads to readout, via close compensation only
// - continuous mode starts the next opening compensation straight after readout
// - triggered mode cleans after readout until a start command or an external trigger edge
// - readout status low in compensation and exposure, high in readout
// - readout status drives the rear logic output pin
// - opening compensation length is fixed internally, not programmed
`timescale 1ns/1ns
module ces_exposure_sequencer
   import ces_pkg::*;
#(
   parameter int unsigned CLEAN_CYC = CLEAN_PAT_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_trigger,
   output logic sensor_clean,
   output logic sensor_accum,
   output logic shutter_drive,
   output logic readout_status
);
   localparam int CLN_W = (CLEAN_CYC > 1) ? $clog2(CLEAN_CYC) : 1;
   localparam logic [CLN_W-1:0] CLN_LAST = CLN_W'(CLEAN_CYC - 1);

   ces_tmr_if #(.W(CNT_W)) tif ();

   ces_interval_timer #(.W(CNT_W)) u_tmr (
      .ref_clk(ref_clk),
      .rst(rst),
      .tif(tif)
   );

   logic trig_edge;

   ces_trig_sync u_trig (
      .ref_clk(ref_clk),
      .rst(rst),
      .trig_pin(ext_trigger),
      .trig_edge(trig_edge)
   );

   // ==========================================================
   // register bus
   logic wr_acc, rd_setup, cmd_start, cmd_stop, mapped;
   logic cont_r, cont_nxt, auto_r, auto_nxt;
   logic [CNT_W-1:0] exp_r, exp_nxt, close_r, close_nxt, read_r, read_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [31:0] frames_r, frames_nxt;

   ces_state_t st_r, st_nxt;
   logic start_pend_r, start_pend_nxt, stop_pend_r, stop_pend_nxt;
   logic [CLN_W-1:0] cln_r, cln_nxt;

   always_comb begin
      wr_acc = psel && penable && pwrite;
      rd_setup = psel && !penable && !pwrite;
      mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STATUS) ||
               (paddr == REG_FRAMES) || (paddr == REG_EXP) || (paddr == REG_CLOSE) ||
               (paddr == REG_READ);
      cmd_start = wr_acc && (paddr == REG_CMD) && pwdata[CMD_START_BIT];
      cmd_stop = wr_acc && (paddr == REG_CMD) && pwdata[CMD_STOP_BIT];
      cont_nxt = cont_r;
      auto_nxt = auto_r;
      exp_nxt = exp_r;
      close_nxt = close_r;
      read_nxt = read_r;
      if (wr_acc) begin
         case (paddr)
            REG_CTRL: begin
               cont_nxt = pwdata[CTRL_CONT_BIT];
               auto_nxt = pwdata[CTRL_AUTO_BIT];
            end
            REG_EXP: exp_nxt = pwdata[CNT_W-1:0];
            REG_CLOSE: close_nxt = pwdata[CNT_W-1:0];
            REG_READ: read_nxt = pwdata[CNT_W-1:0];
            default: ;
         endcase
      end
      // read data captured in setup so it is steady through the access phase
      prdata_nxt = prdata_r;
      if (rd_setup) begin
         prdata_nxt = 32'h00000000;
         case (paddr)
            REG_CTRL: begin
               prdata_nxt[CTRL_CONT_BIT] = cont_r;
               prdata_nxt[CTRL_AUTO_BIT] = auto_r;
            end
            REG_STATUS: begin
               prdata_nxt[2:0] = st_r;
               prdata_nxt[STAT_START_BIT] = start_pend_r;
               prdata_nxt[STAT_STOP_BIT] = stop_pend_r;
               prdata_nxt[STAT_READ_BIT] = readout_status;
               prdata_nxt[STAT_SHUT_BIT] = shutter_drive;
            end
            REG_FRAMES: prdata_nxt = frames_r;
            REG_EXP: prdata_nxt[CNT_W-1:0] = exp_r;
            REG_CLOSE: prdata_nxt[CNT_W-1:0] = close_r;
            REG_READ: prdata_nxt[CNT_W-1:0] = read_r;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cont_r <= 1'b0;
         auto_r <= 1'b0;
         exp_r <= EXP_RST;
         close_r <= CLOSE_RST;
         read_r <= READ_RST;
         prdata_r <= 32'h00000000;
      end else begin
         cont_r <= cont_nxt;
         auto_r <= auto_nxt;
         exp_r <= exp_nxt;
         close_r <= close_nxt;
         read_r <= read_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ==========================================================
   // sequencer
   logic clean_o_nxt, accum_o_nxt, shut_o_nxt, read_o_nxt;
   logic clean_r, accum_r, shut_r, read_o_r;

   always_comb begin
      st_nxt = st_r;
      tif.load = 1'b0;
      tif.value = cyc_min1(CNT_W'(OPEN_CYC));
      cln_nxt = '0;
      frames_nxt = frames_r;
      case (st_r)
         ST_CLEAN: begin
            // a start only takes effect once the current pattern is shifted out
            cln_nxt = (cln_r == CLN_LAST) ? '0 : cln_r + CLN_W'(1);
            if (start_pend_r && (cln_r == CLN_LAST)) begin
               st_nxt = ST_OPEN;
               tif.load = 1'b1;
            end
         end
         ST_OPEN: begin
            if (tif.done) begin
               st_nxt = ST_EXPOSE;
               tif.load = auto_r;
               tif.value = cyc_min1(exp_r);
            end
         end
         ST_EXPOSE: begin
            if (stop_pend_r || (auto_r && tif.done)) begin
               st_nxt = ST_CLOSE;
               tif.load = 1'b1;
               tif.value = cyc_min1(close_r);
            end
         end
         ST_CLOSE: begin
            if (tif.done) begin
               st_nxt = ST_READ;
               tif.load = 1'b1;
               tif.value = cyc_min1(read_r);
            end
         end
         ST_READ: begin
            if (tif.done) begin
               frames_nxt = frames_r + 32'h00000001;
               if (cont_r) begin
                  st_nxt = ST_OPEN;
                  tif.load = 1'b1;
               end else begin
                  st_nxt = ST_CLEAN;
               end
            end
         end
         default: st_nxt = ST_CLEAN;
      endcase
      // set wins over clear for both pending flags
      start_pend_nxt = start_pend_r;
      if ((st_r == ST_CLEAN) && (st_nxt != ST_CLEAN)) begin
         start_pend_nxt = 1'b0;
      end
      if ((st_r == ST_CLEAN) && (cmd_start || trig_edge)) begin
         start_pend_nxt = 1'b1;
      end
      stop_pend_nxt = stop_pend_r;
      if (st_r == ST_CLOSE) begin
         stop_pend_nxt = 1'b0;
      end
      if (cmd_stop && ((st_r == ST_OPEN) || (st_r == ST_EXPOSE))) begin
         stop_pend_nxt = 1'b1;
      end
      clean_o_nxt = (st_nxt == ST_CLEAN);
      accum_o_nxt = (st_nxt == ST_EXPOSE);
      shut_o_nxt = (st_nxt == ST_OPEN) || (st_nxt == ST_EXPOSE);
      read_o_nxt = (st_nxt == ST_READ);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_CLEAN;
         cln_r <= '0;
         start_pend_r <= 1'b0;
         stop_pend_r <= 1'b0;
         frames_r <= 32'h00000000;
         clean_r <= 1'b1;
         accum_r <= 1'b0;
         shut_r <= 1'b0;
         read_o_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cln_r <= cln_nxt;
         start_pend_r <= start_pend_nxt;
         stop_pend_r <= stop_pend_nxt;
         frames_r <= frames_nxt;
         clean_r <= clean_o_nxt;
         accum_r <= accum_o_nxt;
         shut_r <= shut_o_nxt;
         read_o_r <= read_o_nxt;
      end
   end

   assign sensor_clean = clean_r;
   assign sensor_accum = accum_r;
   assign shutter_drive = shut_r;
   assign readout_status = read_o_r;

   // ==========================================================
   // checks
   property p_stop_ends;
      @(posedge ref_clk) disable iff (rst)
         (st_r == ST_EXPOSE && stop_pend_r) |=> !sensor_accum && !shutter_drive;
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("exposure ran past stop");

   property p_idle_clean;
      @(posedge ref_clk) disable iff (rst)
         (st_r == ST_CLEAN && !start_pend_r) |=> sensor_clean && !sensor_accum;
   endproperty
   a_idle_clean: assert property (p_idle_clean) else $error("idle without cleaning");

   property p_clean_first;
      @(posedge ref_clk) disable iff (rst)
         $rose(shutter_drive) |-> $past(sensor_clean) || $past(readout_status);
   endproperty
   a_clean_first: assert property (p_clean_first) else $error("shutter opened uncleaned");

   property p_read_after;
      @(posedge ref_clk) disable iff (rst)
         (st_r == ST_CLOSE && tif.done) |=> readout_status && !sensor_clean;
   endproperty
   a_read_after: assert property (p_read_after) else $error("readout did not follow");

   property p_cont_next;
      @(posedge ref_clk) disable iff (rst)
         (st_r == ST_READ && tif.done && cont_r) |=> shutter_drive && !readout_status;
   endproperty
   a_cont_next: assert property (p_cont_next) else $error("no next exposure");

   property p_trig_clean;
      @(posedge ref_clk) disable iff (rst)
         (st_r == ST_READ && tif.done && !cont_r) |=> sensor_clean ##1 sensor_clean;
   endproperty
   a_trig_clean: assert property (p_trig_clean) else $error("no cleaning after readout");

   property p_status_low;
      @(posedge ref_clk) disable iff (rst)
         (shutter_drive || st_r == ST_CLOSE) |-> !readout_status;
   endproperty
   a_status_low: assert property (p_status_low) else $error("status high outside readout");

   property p_open_auto;
      @(posedge ref_clk) disable iff (rst)
         $rose(shutter_drive) |-> tif.cnt == CNT_W'(OPEN_CYC - 1) && !sensor_accum;
   endproperty
   a_open_auto: assert property (p_open_auto) else $error("open interval not fixed");

   property p_shut_release;
      @(posedge ref_clk) disable iff (rst)
         $fell(shutter_drive) |-> st_r == ST_CLOSE && $past(sensor_accum) ##1 !shutter_drive;
   endproperty
   a_shut_release: assert property (p_shut_release) else $error("shutter release wrong");

   // a start kept from outside cleaning would fire an unasked frame after readout
   property p_start_drop;
      @(posedge ref_clk) disable iff (rst)
         (st_r != ST_CLEAN && !start_pend_r) |=> !start_pend_r;
   endproperty
   a_start_drop: assert property (p_start_drop) else $error("start outside cleaning");

   property p_accum_shut;
      @(posedge ref_clk) disable iff (rst)
         sensor_accum |-> shutter_drive && !sensor_clean;
   endproperty
   a_accum_shut: assert property (p_accum_shut) else $error("accum with shutter shut");
endmodule : ces_exposure_sequencer

// *** rtl/ces_pkg.sv ***
// shared constants, register map and state type of the exposure sequencer
// assumes a 20 MHz ref_clk and an APB master with 32-bit data
package ces_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned OPEN_COMP_NS = 10000;
   // least time, so round up
   localparam int unsigned OPEN_CYC = (OPEN_COMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CLEAN_PAT_CYC = 64;
   localparam int unsigned CNT_W = 24;
   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FRAMES = 8'h0C;
   localparam logic [7:0] REG_EXP = 8'h10;
   localparam logic [7:0] REG_CLOSE = 8'h14;
   localparam logic [7:0] REG_READ = 8'h18;
   // ==========================================================
   // fields
   localparam int unsigned CTRL_CONT_BIT = 0;
   localparam int unsigned CTRL_AUTO_BIT = 1;
   localparam int unsigned CMD_START_BIT = 0;
   localparam int unsigned CMD_STOP_BIT = 1;
   localparam int unsigned STAT_START_BIT = 4;
   localparam int unsigned STAT_STOP_BIT = 5;
   localparam int unsigned STAT_READ_BIT = 8;
   localparam int unsigned STAT_SHUT_BIT = 9;
   // ==========================================================
   // reset values, in clock cycles
   localparam logic [CNT_W-1:0] EXP_RST = 24'h004E20;
   localparam logic [CNT_W-1:0] CLOSE_RST = 24'h0000C8;
   localparam logic [CNT_W-1:0] READ_RST = 24'h001000;
   // ==========================================================
   typedef enum logic [2:0] {ST_CLEAN, ST_OPEN, ST_EXPOSE, ST_CLOSE, ST_READ} ces_state_t;

   // a programmed zero would wrap the timer to its longest interval, so it counts as one cycle
   function automatic logic [CNT_W-1:0] cyc_min1(input logic [CNT_W-1:0] v);
      cyc_min1 = (v == '0) ? CNT_W'(1) : v;
   endfunction : cyc_min1
endpackage : ces_pkg

// *** rtl/ces_tmr_if.sv ***
// load/done link between the sequencer and its interval timer
// assumes both ends sit on ref_clk
`timescale 1ns/1ns
interface ces_tmr_if #(parameter int W = 24);
   logic load;
   logic [W-1:0] value;
   logic [W-1:0] cnt;
   logic busy;
   logic done;
   modport ctrl (output load, output value, input cnt, input busy, input done);
   modport tmr (input load, input value, output cnt, output busy, output done);
endinterface : ces_tmr_if

// *** rtl/ces_interval_timer.sv ***
// down counter timing one interval of value cycles after a load pulse
// assumes value is at least one
`timescale 1ns/1ns
module ces_interval_timer #(
   parameter int W = 24
) (
   input wire logic ref_clk,
   input wire logic rst,
   ces_tmr_if.tmr tif
);
   logic [W-1:0] cnt_r, cnt_nxt;
   logic busy_r, busy_nxt;

   // ==========================================================
   // counter
   always_comb begin
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      if (tif.load) begin
         cnt_nxt = tif.value - W'(1);
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         if (cnt_r == '0) begin
            busy_nxt = 1'b0;
         end else begin
            cnt_nxt = cnt_r - W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign tif.cnt = cnt_r;
   assign tif.busy = busy_r;
   assign tif.done = busy_r && (cnt_r == '0);

   // ==========================================================
   // checks
   property p_done_single;
      @(posedge ref_clk) disable iff (rst) (tif.done && !tif.load) |=> !tif.done;
   endproperty
   a_done_single: assert property (p_done_single) else $error("timer done held too long");
endmodule : ces_interval_timer

// *** rtl/ces_trig_sync.sv ***
// synchronises the external trigger pin and flags its rising edge
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ns
module ces_trig_sync (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic trig_pin,
   output logic trig_edge
);
   logic [2:0] sh_r, sh_nxt;
   logic edge_r, edge_nxt;

   // ==========================================================
   // two-flop sync, edge taken only from the second and third stage
   always_comb begin
      sh_nxt = {sh_r[1:0], trig_pin};
      edge_nxt = sh_r[1] & ~sh_r[2];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sh_r <= 3'h0;
         edge_r <= 1'b0;
      end else begin
         sh_r <= sh_nxt;
         edge_r <= edge_nxt;
      end
   end

   assign trig_edge = edge_r;

   // ==========================================================
   // checks
   property p_edge_pulse;
      @(posedge ref_clk) disable iff (rst) edge_r |=> !edge_r;
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) else $error("trigger edge longer than one cycle");
endmodule : ces_trig_sync

// *** verif/ces_trig_src.sv ***
// external trigger source standing outside the camera
// assumes fire comes from the bench; the pin is not tied to ref_clk
`timescale 1ns/1ns
module ces_trig_src (
   input wire logic fire,
   output logic ext_trigger
);
   // ==========================================================
   // pulse
   initial ext_trigger = 1'h0;
   // odd offset keeps the pin edge away from the camera clock edges
   always @(posedge fire) begin
      #37;
      ext_trigger = 1'h1;
      #310;
      ext_trigger = 1'h0;
   end
endmodule : ces_trig_src

// *** verif/test_ccd_exposure_sequencer.sv ***
// self-checking bench for the exposure sequencer
// assumes ces_pkg and the trigger source model are compiled first
`timescale 1ns/1ns
module test_ccd_exposure_sequencer;
   import ces_pkg::*;
   localparam int unsigned CLN = 4;
   localparam int unsigned OPN = (OPEN_COMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, fire, ext_trigger;
   logic sensor_clean, sensor_accum, shutter_drive, readout_status;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic err, pcl, prd, nsh, ncl;
   int unsigned errors, tests_run, frames, sh_c, ac_c, rd_c, gp_c, sh_l, ac_l, rd_l, gp_l;
   int unsigned e, c, r, n, seed;
   // ==========================================================
   // design and far side
   ces_exposure_sequencer #(.CLEAN_CYC(CLN)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_trigger(ext_trigger),
      .sensor_clean(sensor_clean), .sensor_accum(sensor_accum),
      .shutter_drive(shutter_drive), .readout_status(readout_status));
   ces_trig_src src (.fire(fire), .ext_trigger(ext_trigger));
   initial ref_clk = 1'h0;
   always #25 ref_clk = ~ref_clk;
   // ==========================================================
   // helpers
   function automatic int unsigned mn(input int unsigned v);
      mn = (v == 0) ? 1 : v;
   endfunction : mn
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      rd = prdata;
      err = pslverr;
      check(pready, 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic get(input logic [7:0] a, input logic [31:0] want);
      apb(1'h0, a, 32'h0);
      check(rd, want);
   endtask : get
   task automatic wait_frame();
      int unsigned f0, k;
      f0 = frames;
      k = 0;
      while (frames == f0 && k < 9000) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 9000) check(32'h0, 32'h1);
   endtask : wait_frame
   task automatic chk_frame(input int unsigned cc, input int unsigned rr, input logic cont);
      check(sh_l - ac_l, OPN);
      check(gp_l, mn(cc));
      check(rd_l, mn(rr));
      check(nsh, cont);
      check(ncl, !cont);
   endtask : chk_frame
   // ==========================================================
   // monitor: run lengths per frame, closed when readout ends
   always @(negedge ref_clk) begin
      if (!rst) begin
         if (prd && !readout_status) begin
            sh_l = sh_c;
            ac_l = ac_c;
            rd_l = rd_c;
            gp_l = gp_c;
            {sh_c, ac_c, rd_c, gp_c} = '0;
            nsh = shutter_drive;
            ncl = sensor_clean;
            frames++;
         end
         sh_c += shutter_drive;
         ac_c += sensor_accum;
         rd_c += readout_status;
         gp_c += !(shutter_drive | readout_status | sensor_clean);
         check(readout_status & (shutter_drive | sensor_accum | sensor_clean), 0);
         check(sensor_accum & ~shutter_drive, 0);
         if (pcl && !sensor_clean) check(shutter_drive & ~sensor_accum, 1);
         pcl = sensor_clean;
         prd = readout_status;
      end
   end
   // ==========================================================
   // watchdog, far beyond the few thousand cycles the run needs
   initial begin
      #(30000 * 50);
      errors++;
      complete_run();
   end
   // ==========================================================
   // main sequence
   initial begin
      seed = $urandom(73866);
      {rst, psel, penable, pwrite, fire, pcl, prd} = 7'h41;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      @(negedge ref_clk);
      check({sensor_clean, shutter_drive, sensor_accum, readout_status}, 4'h8);
      get(REG_CTRL, 32'h0);
      get(REG_EXP, 32'h00004E20);
      get(REG_CLOSE, 32'h000000C8);
      get(REG_READ, 32'h00001000);
      get(REG_STATUS, 32'h0);
      get(REG_CMD, 32'h0);
      check(err, 1'h0);
      get(8'h1C, 32'h0);
      check(err, 1'h1);
      apb(1'h1, REG_FRAMES, 32'hFF);
      get(REG_FRAMES, 32'h0);
      repeat (3 * CLN) @(negedge ref_clk);
      check(sensor_clean, 1'h1);
      // triggered frames; start by command or by the trigger pin alternately
      for (int i = 0; i < 4; i++) begin
         e = (i == 0) ? 0 : $urandom_range(8, 1);
         c = $urandom_range(4, 1);
         r = (i == 3) ? 40 : $urandom_range(5, 1);
         apb(1'h1, REG_EXP, e);
         apb(1'h1, REG_CLOSE, c);
         apb(1'h1, REG_READ, r);
         apb(1'h1, REG_CTRL, 32'h2);
         if (i[0]) begin
            @(posedge ref_clk);
            fire <= 1'h1;
            @(posedge ref_clk);
            fire <= 1'h0;
         end else begin
            apb(1'h1, REG_CMD, 32'h1);
         end
         if (i == 3) begin
            // a start during readout must be dropped
            n = 0;
            while (!readout_status && n < 2000) begin
               @(negedge ref_clk);
               n++;
            end
            apb(1'h1, REG_CMD, 32'h1);
         end
         wait_frame();
         chk_frame(c, r, 1'h0);
         check(ac_l, mn(e));
         repeat (3 * CLN + 8) @(negedge ref_clk);
         check(sensor_clean, 1'h1);
         get(REG_FRAMES, i + 1);
      end
      // continuous pair, then back to triggered mode mid-frame
      apb(1'h1, REG_EXP, 32'h3);
      apb(1'h1, REG_CLOSE, 32'h2);
      apb(1'h1, REG_READ, 32'h2);
      apb(1'h1, REG_CTRL, 32'h3);
      apb(1'h1, REG_CMD, 32'h1);
      wait_frame();
      chk_frame(2, 2, 1'h1);
      apb(1'h1, REG_CTRL, 32'h2);
      wait_frame();
      chk_frame(2, 2, 1'h0);
      check(ac_l, 3);
      // manual stop ends exposure
      apb(1'h1, REG_CTRL, 32'h0);
      // a stop while cleaning must be dropped, else the exposure below ends at once
      apb(1'h1, REG_CMD, 32'h2);
      apb(1'h1, REG_CMD, 32'h1);
      n = 0;
      while (!sensor_accum && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      e = $urandom_range(10, 3);
      repeat (e) @(negedge ref_clk);
      check(sensor_accum, 1'h1);
      apb(1'h1, REG_CMD, 32'h2);
      wait_frame();
      chk_frame(2, 2, 1'h0);
      check(ac_l >= e + 2 && ac_l <= e + 6, 1'h1);
      complete_run();
   end
endmodule : test_ccd_exposure_sequencer
